// File: src/bwcr_map.vh
`ifndef BWCR_MAP_VH
`define BWCR_MAP_VH
// Dword offsets of the configuration space
`define BWCR_OFF_PREF_BASE    8'h24
`define BWCR_OFF_PREF_BOT_HI  8'h28
`define BWCR_OFF_PREF_TOP_HI  8'h2C
`define BWCR_OFF_IO_HI        8'h30
`define BWCR_OFF_CAP          8'h34
`define BWCR_OFF_IRQ          8'h3C
// Reset and constant values
`define BWCR_ADDR64_CODE      4'h1
`define BWCR_CAP_HEAD         8'h40
`define BWCR_PIN_UP           8'h00
`define BWCR_PIN_DOWN         8'h01
`define BWCR_ZERO12           12'h000
`define BWCR_ZERO16           16'h0000
`define BWCR_ZERO32           32'h00000000
`define BWCR_ZERO8            8'h00
`define BWCR_LOW20_ZERO       20'h00000
`define BWCR_LOW20_ONES       20'hFFFFF
`define BWCR_LOW16_ZERO       16'h0000
`define BWCR_LOW16_ONES       16'hFFFF
`endif

// File: src/bwcr_range_check.v
`timescale 1ns/1ps
// ==========================================================
// Inclusive range compare, registered
module bwcr_range_check
(
  // Clocking
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        clkEn,
  // Request
  input  wire        reqValid,
  input  wire [63:0] reqAddr,
  input  wire [63:0] bottomAddr,
  input  wire [63:0] topAddr,
  // Result
  output reg         hit_q
);
  // Hit when bottom <= addr <= top
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      hit_q <= 1'b0;
    else if (clkEn)
      hit_q <= reqValid && (bottomAddr <= reqAddr) && (reqAddr <= topAddr);
  end
endmodule // bwcr_range_check

// File: src/bwcr_io_check.v
`timescale 1ns/1ps
// ==========================================================
// I/O window compare on 32-bit addresses, registered
module bwcr_io_check
(
  // Clocking
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        clkEn,
  // Request
  input  wire        reqValid,
  input  wire [31:0] reqAddr,
  input  wire [31:0] bottomAddr,
  input  wire [31:0] topAddr,
  // Result
  output reg         hit_q
);
  // Inclusive compare
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      hit_q <= 1'b0;
    else if (clkEn)
      hit_q <= reqValid && (bottomAddr <= reqAddr) && (reqAddr <= topAddr);
  end
endmodule // bwcr_io_check

// File: src/bwcr_regs.v
`timescale 1ns/1ps
`include "bwcr_map.vh"
// Overview of operation
// - Bits 19:16 of the prefetchable limit word always read 1h for 64-bit addressing.
// - Limit bits 31:20 give top address bits 31:20, with low 20 bits taken as ones.
// - Memory requests inside the 64-bit prefetchable window are forwarded.
// - A 32-bit RW register reset to zero gives window bottom bits 63:32.
// - A 32-bit RW register reset to zero gives window top bits 63:32.
// - Offset 30h bits 15:0 hold I/O bottom bits 31:16, reset zero.
// - Offset 30h bits 31:16 hold I/O top bits 31:16, reset zero.
// - I/O requests are forwarded only inside the 32-bit I/O window.
// - The capability pointer is read-only and reads 40h.
// - Interrupt line is RW storage reset to 00h with no effect.
// - Interrupt pin reads 00h upstream and 01h downstream.
// - Downstream ports send INTA messages for hot-plug events.
// - Base bits 15:4 give bottom bits 31:20, with low 20 bits taken as zero.
module bwcr_regs
(
  // Clocking
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire        clkEn,
  // Port strap, level from same-clock logic
  input  wire        isDownstream,
  // Configuration access
  input  wire        cfgWrite,
  input  wire        cfgRead,
  input  wire [7:0]  cfgAddr,
  input  wire [3:0]  cfgByteEn,
  input  wire [31:0] cfgWrData,
  output reg  [31:0] cfgRdData_q,
  output reg         cfgRdValid_q,
  // Memory request for forwarding decision
  input  wire        memReqValid,
  input  wire [63:0] memReqAddr,
  output wire        memForward,
  // I/O request for forwarding decision
  input  wire        ioReqValid,
  input  wire [31:0] ioReqAddr,
  output wire        ioForward,
  // Hot-plug event and INTA message request
  input  wire        hotPlugEvent,
  output reg         intaAssert_q,
  output reg         intaMsgPulse_q
);
  // ==========================================================
  // Storage
  reg [11:0] prefBase_q;
  reg [11:0] prefTop_q;
  reg [31:0] prefBotHi_q;
  reg [31:0] prefTopHi_q;
  reg [15:0] ioBotHi_q;
  reg [15:0] ioTopHi_q;
  reg [7:0]  irqLine_q;
  reg        isDown_q;

  // Byte-enable merge, used for every writable word
  function [31:0] merge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  be;
    integer i;
    begin
      merge = oldVal;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = newVal[i*8 +: 8];
    end
  endfunction

  wire [31:0] prefWord = {prefTop_q, `BWCR_ADDR64_CODE, prefBase_q, `BWCR_ADDR64_CODE};
  wire [31:0] prefNew  = merge(prefWord, cfgWrData, cfgByteEn);
  wire [31:0] ioWord   = {ioTopHi_q, ioBotHi_q};
  wire [31:0] ioNew    = merge(ioWord, cfgWrData, cfgByteEn);
  wire [31:0] irqWord  = {16'h0000, isDown_q ? `BWCR_PIN_DOWN : `BWCR_PIN_UP, irqLine_q};
  wire [31:0] irqNew   = merge(irqWord, cfgWrData, cfgByteEn);

  // ==========================================================
  // Register writes; read-only fields ignore the data
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      prefBase_q  <= `BWCR_ZERO12;
      prefTop_q   <= `BWCR_ZERO12;
      prefBotHi_q <= `BWCR_ZERO32;
      prefTopHi_q <= `BWCR_ZERO32;
      ioBotHi_q   <= `BWCR_ZERO16;
      ioTopHi_q   <= `BWCR_ZERO16;
      irqLine_q   <= `BWCR_ZERO8;
    end
    else if (clkEn && cfgWrite)
    begin
      case (cfgAddr)
        `BWCR_OFF_PREF_BASE:
        begin
          prefBase_q <= prefNew[15:4];
          prefTop_q  <= prefNew[31:20];
        end
        `BWCR_OFF_PREF_BOT_HI: prefBotHi_q <= merge(prefBotHi_q, cfgWrData, cfgByteEn);
        `BWCR_OFF_PREF_TOP_HI: prefTopHi_q <= merge(prefTopHi_q, cfgWrData, cfgByteEn);
        `BWCR_OFF_IO_HI:
        begin
          ioBotHi_q <= ioNew[15:0];
          ioTopHi_q <= ioNew[31:16];
        end
        `BWCR_OFF_IRQ: irqLine_q <= irqNew[7:0];
        default: ;
      endcase
    end
  end

  // Strap taken on every enabled clock, also while under reset, as it has no reset
  always @(posedge clk_sys)
  begin
    if (clkEn)
      isDown_q <= isDownstream;
  end

  // ==========================================================
  // Read path, one cycle latency; unmapped offsets read zero
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cfgRdData_q  <= `BWCR_ZERO32;
      cfgRdValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      cfgRdValid_q <= cfgRead;
      if (cfgRead)
      begin
        case (cfgAddr)
          `BWCR_OFF_PREF_BASE:   cfgRdData_q <= prefWord;
          `BWCR_OFF_PREF_BOT_HI: cfgRdData_q <= prefBotHi_q;
          `BWCR_OFF_PREF_TOP_HI: cfgRdData_q <= prefTopHi_q;
          `BWCR_OFF_IO_HI:       cfgRdData_q <= ioWord;
          `BWCR_OFF_CAP:         cfgRdData_q <= {24'h000000, `BWCR_CAP_HEAD};
          `BWCR_OFF_IRQ:         cfgRdData_q <= irqWord;
          default:               cfgRdData_q <= `BWCR_ZERO32;
        endcase
      end
    end
  end

  // ==========================================================
  // Window bounds; a top below the bottom simply never hits
  wire [63:0] prefBottom = {prefBotHi_q, prefBase_q, `BWCR_LOW20_ZERO};
  wire [63:0] prefTopA   = {prefTopHi_q, prefTop_q, `BWCR_LOW20_ONES};
  wire [31:0] ioBottom   = {ioBotHi_q, `BWCR_LOW16_ZERO};
  wire [31:0] ioTopA     = {ioTopHi_q, `BWCR_LOW16_ONES};

  bwcr_range_check uMemCheck
  (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .clkEn      (clkEn),
    .reqValid   (memReqValid),
    .reqAddr    (memReqAddr),
    .bottomAddr (prefBottom),
    .topAddr    (prefTopA),
    .hit_q      (memForward)
  );

  bwcr_io_check uIoCheck
  (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .clkEn      (clkEn),
    .reqValid   (ioReqValid),
    .reqAddr    (ioReqAddr),
    .bottomAddr (ioBottom),
    .topAddr    (ioTopA),
    .hit_q      (ioForward)
  );

  // ==========================================================
  // INTA virtual wire: downstream only, one message per level change
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      intaAssert_q   <= 1'b0;
      intaMsgPulse_q <= 1'b0;
    end
    else if (clkEn)
    begin
      intaAssert_q   <= isDown_q && hotPlugEvent;
      intaMsgPulse_q <= (isDown_q && hotPlugEvent) != intaAssert_q;
    end
  end
endmodule // bwcr_regs

// File: dv/bwcr_regs_sva.sv
`timescale 1ns/1ps
// ====
// Port checker
module bwcr_regs_chk
(
  // Watched ports
  input wire        clk_sys,
  input wire        resetn,
  input wire        clkEn,
  input wire        isDownstream,
  input wire        cfgRead,
  input wire [7:0]  cfgAddr,
  input wire [31:0] cfgRdData_q,
  input wire        cfgRdValid_q,
  input wire        memReqValid,
  input wire        memForward,
  input wire        ioReqValid,
  input wire        ioForward,
  input wire        hotPlugEvent,
  input wire        intaAssert_q,
  input wire        intaMsgPulse_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Event rising on a port that was already downstream
  sequence hpRise;
    $rose(hotPlugEvent) && isDownstream && $past(isDownstream);
  endsequence
  rd_valid_a: assert property (cfgRead && clkEn |=> cfgRdValid_q)
    else $error("no read valid");
  cap_head_a: assert property (cfgRead && clkEn && cfgAddr == 8'h34 |=>
    cfgRdData_q == 32'h00000040) else $error("cap pointer");
  addr64_code_a: assert property (cfgRead && clkEn && cfgAddr == 8'h24 |=>
    cfgRdData_q[19:16] == 4'h1) else $error("64-bit code");
  pin_code_a: assert property (cfgRead && clkEn && cfgAddr == 8'h3C && $stable(isDownstream)
    |=> cfgRdData_q[15:8] == {7'h00, $past(isDownstream)}) else $error("pin code");
  inta_rise_a: assert property (clkEn && hpRise |=> intaAssert_q && intaMsgPulse_q)
    else $error("no inta");
  msg_change_a: assert property (intaMsgPulse_q |-> intaAssert_q != $past(intaAssert_q))
    else $error("stray msg");
  up_quiet_a: assert property (!isDownstream [*3] |=> !intaAssert_q) else $error("up inta");
  mem_idle_a: assert property (!memReqValid |=> !memForward) else $error("mem flag");
  io_idle_a: assert property (!ioReqValid |=> !ioForward) else $error("io flag");
endmodule // bwcr_regs_chk

// File: dv/bwcr_host_model.sv
`timescale 1ns/1ps
// ====
// Configuration requester
module bwcr_host_model
(
  // Clock
  input wire          clk_sys,
  // Request
  output logic        cfgWrite = 1'h0,
  output logic        cfgRead = 1'h0,
  output logic [7:0]  cfgAddr = 8'h00,
  output logic [3:0]  cfgByteEn = 4'h0,
  output logic [31:0] cfgWrData = 32'h00000000,
  // Answer
  input wire   [31:0] cfgRdData_q
);
  // Single write; released write data is inverted so stale values never look valid, address and byte enables are held
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    cfgWrite = 1'h1;
    @(negedge clk_sys);
    cfgWrite = 1'h0;
    cfgWrData = ~d;
  endtask
  // Single read; data stands after the taking edge
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    cfgAddr = a;
    cfgRead = 1'h1;
    @(negedge clk_sys);
    cfgRead = 1'h0;
    cfgAddr = ~a;
    d = cfgRdData_q;
  endtask
endmodule // bwcr_host_model

// File: dv/bwcr_regs_tb_top.sv
`timescale 1ns/1ps
// ====
// Testbench
module bwcr_regs_tb_top;
  logic        clk_sys = 1'h0;
  logic        resetn = 1'h0;
  logic        clkEn = 1'h1;
  logic        isDownstream = 1'h1;
  logic        memReqValid = 1'h0;
  logic [63:0] memReqAddr = 64'h0;
  logic        ioReqValid = 1'h0;
  logic [31:0] ioReqAddr = 32'h0;
  logic        hotPlugEvent = 1'h0;
  logic [31:0] rdVal;
  wire         cfgWrite, cfgRead, cfgRdValid_q, memForward, ioForward;
  wire         intaAssert_q, intaMsgPulse_q;
  wire  [7:0]  cfgAddr;
  wire  [3:0]  cfgByteEn;
  wire  [31:0] cfgWrData, cfgRdData_q;
  int          fail_count = 0;
  int          tests_run = 0;
  bwcr_regs i_bwcr_regs (.*);
  bwcr_host_model i_bwcr_host_model (.*);
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    i_bwcr_host_model.rd(a, rdVal);
    chk(rdVal, exp);
  endtask
  // One request; the flag is looked at one cycle later
  task fwd(input logic io, input logic [63:0] a, input logic exp);
    @(negedge clk_sys);
    memReqValid = !io;
    ioReqValid = io;
    memReqAddr = a;
    ioReqAddr = a[31:0];
    @(negedge clk_sys);
    chk({30'h0, ioForward, memForward}, {30'h0, io & exp, !io & exp});
    memReqValid = 1'h0;
    ioReqValid = 1'h0;
  endtask
  task wrap_up;
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (2) @(negedge clk_sys);
    rdc(8'h24, 32'h00010001);
    rdc(8'h28, 32'h0);
    rdc(8'h2C, 32'h0);
    rdc(8'h30, 32'h0);
    rdc(8'h34, 32'h40);
    rdc(8'h3C, 32'h100);
    i_bwcr_host_model.wr(8'h34, 4'hF, 32'hFFFFFFFF);
    rdc(8'h34, 32'h40);
    i_bwcr_host_model.wr(8'h24, 4'hF, 32'hFFFFFFFF);
    rdc(8'h24, 32'hFFF1FFF1);
    i_bwcr_host_model.wr(8'h28, 4'h5, 32'hAABBCCDD);
    rdc(8'h28, 32'h00BB00DD);
    i_bwcr_host_model.wr(8'h30, 4'hF, 32'h00020001);
    rdc(8'h30, 32'h00020001);
    i_bwcr_host_model.wr(8'h3C, 4'hF, 32'hFFFFFFFF);
    rdc(8'h3C, 32'h000001FF);
    // A write while the enable is low must leave the line untouched
    clkEn = 1'h0;
    i_bwcr_host_model.wr(8'h3C, 4'hF, 32'h00000055);
    clkEn = 1'h1;
    rdc(8'h3C, 32'h000001FF);
    i_bwcr_host_model.wr(8'h24, 4'hF, 32'h20011001);
    i_bwcr_host_model.wr(8'h28, 4'hF, 32'h1);
    i_bwcr_host_model.wr(8'h2C, 4'hF, 32'h1);
    fwd(1'h0, 64'h1_10000000, 1'h1);
    fwd(1'h0, 64'h1_0FFFFFFF, 1'h0);
    fwd(1'h0, 64'h1_200FFFFF, 1'h1);
    fwd(1'h0, 64'h1_20100000, 1'h0);
    fwd(1'h0, 64'h0_15000000, 1'h0);
    fwd(1'h0, 64'h2_15000000, 1'h0);
    fwd(1'h1, 64'h00010000, 1'h1);
    fwd(1'h1, 64'h0000FFFF, 1'h0);
    fwd(1'h1, 64'h0002FFFF, 1'h1);
    fwd(1'h1, 64'h00030000, 1'h0);
    hotPlugEvent = 1'h1;
    @(negedge clk_sys);
    chk({30'h0, intaAssert_q, intaMsgPulse_q}, 32'h3);
    @(negedge clk_sys);
    chk({30'h0, intaAssert_q, intaMsgPulse_q}, 32'h2);
    hotPlugEvent = 1'h0;
    @(negedge clk_sys);
    chk({30'h0, intaAssert_q, intaMsgPulse_q}, 32'h1);
    isDownstream = 1'h0;
    repeat (3) @(negedge clk_sys);
    rdc(8'h3C, 32'h000000FF);
    hotPlugEvent = 1'h1;
    repeat (2) @(negedge clk_sys);
    chk({30'h0, intaAssert_q, intaMsgPulse_q}, 32'h0);
    wrap_up;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #20000;
    fail_count++;
    wrap_up;
  end
endmodule // bwcr_regs_tb_top
bind bwcr_regs bwcr_regs_chk i_bwcr_regs_chk (.*);
